/* File: dpv_dac_path.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dpv_consts.svh"
module dpv_dac_path
  import dpv_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire dpv_stereo_s audio_in,
  input  wire logic        sample_valid,
  input  wire logic        ref_clk_1mhz,
  input  wire logic        hs_present_pin,
  input  wire logic        hs_mic_pin,
  input  wire logic        hs_button_pin,
  output logic [15:0]      dac_sample,
  output logic             dac_sample_valid,
  output logic             dac_power_on,
  output logic [7:0]       dac_applied_gain,
  output dpv_comp_s        comp_ctrl,
  output logic             irq
);
  logic [7:0]  setup_reg, mute_reg, gain_reg, rsvd66_reg, hs_reg, comp_reg;
  logic [1:0]  irq_stat_reg, irq_mask_reg, irq_set;
  logic [1:0]  hs_stat_reg;
  logic        btn_stable_reg, btn_prev_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        w_strb0_reg;
  logic        wr_fire, wr_hit, rd_hit;
  logic [9:0]  wr_idx, rd_idx;
  logic [7:0]  rd_byte;
  dpv_step_e   step_mode;
  dpv_src_e    src_sel;

  assign step_mode = dpv_step_e'(setup_reg[1:0]);
  assign src_sel   = dpv_src_e'(setup_reg[5:4]);

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx  = aw_addr_reg[11:2];
  assign rd_idx  = s_axi_araddr[11:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DPV_RESP_OKAY;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h00000000;
      w_strb0_reg   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb0_reg  <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DPV_RESP_OKAY : `DPV_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Decode of mapped indices, shared by both directions
  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx >= `DPV_IDX_SETUP && idx <= `DPV_IDX_COMP) ||
                 idx == `DPV_IDX_IRQ_STAT || idx == `DPV_IDX_IRQ_MASK;
  endfunction
  assign wr_hit = idx_mapped(wr_idx);
  assign rd_hit = idx_mapped(rd_idx);

  // Register writes; byte lane 0 carries every register
  // R14 reserved bits stored as written, software keeps them at reset value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_reg    <= `DPV_RST_SETUP;
      mute_reg     <= `DPV_RST_MUTE;
      gain_reg     <= `DPV_RST_GAIN;
      rsvd66_reg   <= `DPV_RST_RSVD66;
      hs_reg       <= `DPV_RST_HEADSET;
      comp_reg     <= `DPV_RST_COMP;
      irq_mask_reg <= 2'h0;
    end else if (wr_fire && w_strb0_reg) begin
      unique case (wr_idx)
        `DPV_IDX_SETUP:    setup_reg    <= w_data_reg[7:0];
        `DPV_IDX_MUTE:     mute_reg     <= w_data_reg[7:0];
        `DPV_IDX_GAIN:     gain_reg     <= w_data_reg[7:0];
        `DPV_IDX_RSVD66:   rsvd66_reg   <= w_data_reg[7:0];
        `DPV_IDX_HEADSET:  hs_reg       <= w_data_reg[7:0];
        `DPV_IDX_COMP:     comp_reg     <= w_data_reg[7:0];
        `DPV_IDX_IRQ_MASK: irq_mask_reg <= w_data_reg[1:0];
        default: ;
      endcase
    end
  end

  // Read mux; headset status bits show live detector state
  always_comb begin
    unique case (rd_idx)
      `DPV_IDX_SETUP:    rd_byte = setup_reg;
      `DPV_IDX_MUTE:     rd_byte = mute_reg;
      `DPV_IDX_GAIN:     rd_byte = gain_reg;
      `DPV_IDX_RSVD66:   rd_byte = rsvd66_reg;
      // R8 status read only in D6-D5
      `DPV_IDX_HEADSET:  rd_byte = {hs_reg[7], hs_stat_reg, hs_reg[4:0]};
      `DPV_IDX_COMP:     rd_byte = comp_reg;
      `DPV_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
      `DPV_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
      default:           rd_byte = 8'h00;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DPV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? `DPV_RESP_OKAY : `DPV_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Playback path
  logic        half_phase_reg;
  logic [16:0] avg_sum;
  logic [15:0] src_sample;
  logic        step_due;
  assign avg_sum = {audio_in.left[15], audio_in.left} +
                   {audio_in.right[15], audio_in.right};

  // R2 source selection
  always_comb begin
    unique case (src_sel)
      DPV_SRC_OFF:   src_sample = 16'h0000;
      DPV_SRC_LEFT:  src_sample = audio_in.left;
      DPV_SRC_RIGHT: src_sample = audio_in.right;
      DPV_SRC_AVG:   src_sample = avg_sum[16:1];
    endcase
  end

  // R1 R5 power and mute force silence; data stays held until next sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_sample       <= 16'h0000;
      dac_sample_valid <= 1'b0;
      dac_power_on     <= 1'b0;
    end else begin
      dac_power_on     <= setup_reg[`DPV_BIT_POWER];
      dac_sample_valid <= sample_valid && setup_reg[`DPV_BIT_POWER];
      if (sample_valid) begin
        dac_sample <= (!setup_reg[`DPV_BIT_POWER] ||
                       mute_reg[`DPV_BIT_MUTE]) ? 16'h0000 : src_sample;
      end
    end
  end

  // R3 step cadence; reserved code 11 behaves as no stepping
  assign step_due = sample_valid &&
                    (step_mode == DPV_STEP_EVERY ||
                     (step_mode == DPV_STEP_HALF && half_phase_reg));

  // R6 R15 applied gain walks half a dB per step to the signed target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_applied_gain <= `DPV_RST_GAIN;
      half_phase_reg   <= 1'b0;
    end else begin
      if (sample_valid)
        half_phase_reg <= !half_phase_reg;
      if (step_mode == DPV_STEP_NONE || step_mode == DPV_STEP_RSVD)
        dac_applied_gain <= gain_reg;
      else if (step_due) begin
        if ($signed(dac_applied_gain) < $signed(gain_reg))
          dac_applied_gain <= dac_applied_gain + 8'h01;
        else if ($signed(dac_applied_gain) > $signed(gain_reg))
          dac_applied_gain <= dac_applied_gain - 8'h01;
      end
    end
  end

  // R12 R13 compressor settings handed to the gain stage
  always_ff @(posedge aclk) begin
    if (!aresetn)
      comp_ctrl <= '{1'b0, 3'h3, 2'h3};
    else
      comp_ctrl <= '{comp_reg[`DPV_BIT_COMP_EN], comp_reg[4:2],
                     comp_reg[1:0]};
  end

  //////////////////////////////////////////////////////////////////////////
  // Headset detection and debounce
  logic [3:0] sync1_reg, sync2_reg;
  logic       ref_prev_reg, ms_tick;
  logic [9:0] us_cnt_reg;
  logic [6:0] ms_cnt_reg;
  logic [1:0] hs_cand_reg, hs_deb_reg;
  logic [2:0] hs_agree_reg, btn_agree_reg;
  logic       btn_cand_reg;
  logic       hs_sample, btn_sample;
  logic [6:0] hs_period, btn_period;

  // Pins and reference clock pass two flip-flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {ref_clk_1mhz, hs_button_pin, hs_mic_pin, hs_present_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // R11 one ms tick from rising edges of the 1 MHz reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_reg <= 1'b0;
      us_cnt_reg   <= 10'h000;
      ms_tick      <= 1'b0;
      ms_cnt_reg   <= 7'h00;
    end else begin
      ref_prev_reg <= sync2_reg[3];
      ms_tick      <= 1'b0;
      if (sync2_reg[3] && !ref_prev_reg) begin
        if (us_cnt_reg == 10'(`DPV_REF_PER_MS - 1)) begin
          us_cnt_reg <= 10'h000;
          ms_tick    <= 1'b1;
        end else
          us_cnt_reg <= us_cnt_reg + 10'h001;
      end
      if (ms_tick)
        ms_cnt_reg <= ms_cnt_reg + 7'h01;
    end
  end

  // R9 R10 sample intervals: 2 ms doubling per code, button 1 ms doubling
  assign hs_period  = 7'h02 << hs_reg[4:2];
  assign btn_period = 7'h01 << (hs_reg[1:0] - 2'h1);
  assign hs_sample  = ms_tick && ((ms_cnt_reg & (hs_period - 7'h01)) == 7'h00);
  assign btn_sample = ms_tick &&
                      ((ms_cnt_reg & (btn_period - 7'h01)) == 7'h00);

  // R9 eight agreeing samples span the debounce time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_cand_reg  <= 2'h0;
      hs_agree_reg <= 3'h0;
      hs_deb_reg   <= 2'h0;
    end else if (hs_sample) begin
      if (sync2_reg[1:0] != hs_cand_reg) begin
        hs_cand_reg  <= sync2_reg[1:0];
        hs_agree_reg <= 3'h0;
      end else if (hs_agree_reg == 3'(`DPV_DEB_SAMPLES - 1))
        hs_deb_reg   <= hs_cand_reg;
      else
        hs_agree_reg <= hs_agree_reg + 3'h1;
    end
  end

  // R10 button: code 00 follows the pin directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_cand_reg   <= 1'b0;
      btn_agree_reg  <= 3'h0;
      btn_stable_reg <= 1'b0;
    end else if (hs_reg[1:0] == 2'h0)
      btn_stable_reg <= sync2_reg[2];
    else if (btn_sample) begin
      if (sync2_reg[2] != btn_cand_reg) begin
        btn_cand_reg  <= sync2_reg[2];
        btn_agree_reg <= 3'h0;
      end else if (btn_agree_reg == 3'(`DPV_DEB_SAMPLES - 1))
        btn_stable_reg <= btn_cand_reg;
      else
        btn_agree_reg <= btn_agree_reg + 3'h1;
    end
  end

  // R8 status code; mic without presence cannot form reserved 10
  always_ff @(posedge aclk) begin
    if (!aresetn)
      hs_stat_reg <= 2'h0;
    else if (!hs_reg[`DPV_BIT_HS_EN] || !hs_deb_reg[0])
      hs_stat_reg <= 2'h0;
    else
      hs_stat_reg <= {hs_deb_reg[1], 1'b1};
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts: bit0 headset status change, bit1 button press
  logic [1:0] hs_stat_prev_reg;
  assign irq_set = {btn_stable_reg && !btn_prev_reg,
                    hs_stat_reg != hs_stat_prev_reg};

  // Set beats a same-cycle write-one clear so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg     <= 2'h0;
      hs_stat_prev_reg <= 2'h0;
      btn_prev_reg     <= 1'b0;
      irq              <= 1'b0;
    end else begin
      hs_stat_prev_reg <= hs_stat_reg;
      btn_prev_reg     <= btn_stable_reg;
      irq_stat_reg     <= (irq_stat_reg &
                           ~((wr_fire && w_strb0_reg &&
                              wr_idx == `DPV_IDX_IRQ_STAT) ?
                             w_data_reg[1:0] : 2'h0)) | irq_set;
      irq              <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_step_mode_held;
    step_mode == DPV_STEP_EVERY ##1 step_mode == DPV_STEP_EVERY;
  endsequence
  sequence s_muted_sample;
    mute_reg[`DPV_BIT_MUTE] && sample_valid;
  endsequence

  // R1 power-down gate
  a_power_down: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    !setup_reg[`DPV_BIT_POWER] |=> !dac_power_on && !dac_sample_valid)
    else $error("DAC powered while power bit clear");
  // R2 path off yields silence
  a_path_off: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    sample_valid && src_sel == DPV_SRC_OFF |=> dac_sample == 16'h0000)
    else $error("Off path produced audio");
  // R2 left source passes left data
  a_left_pass: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    sample_valid && src_sel == DPV_SRC_LEFT && setup_reg[7] && !mute_reg[3]
    |=> dac_sample == $past(audio_in.left))
    else $error("Left source not passed");
  // R5 mute forces zero
  a_mute_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    s_muted_sample |=> dac_sample == 16'h0000)
    else $error("Muted output not silent");
  // R3 no stepping applies target directly
  a_step_none: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    step_mode == DPV_STEP_NONE |=> dac_applied_gain == $past(gain_reg))
    else $error("Unstepped gain not applied");
  // R15 one half-dB step per sample up toward a higher target
  a_step_size: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    s_step_mode_held ##0 (sample_valid && gain_reg == $past(gain_reg) &&
      $signed(dac_applied_gain) < $signed(gain_reg))
    |=> dac_applied_gain == $past(dac_applied_gain) + 8'h01)
    else $error("Gain step not one unit");
  // R8 reserved code never reported, disabled reads zero
  a_hs_status: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (hs_stat_reg != 2'h2) and (!hs_reg[7] |=> hs_stat_reg == 2'h0))
    else $error("Headset status illegal");
  // R11 no ms tick in the eight clock cycles after a tick
  a_ms_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    ms_tick |=> !ms_tick [*8])
    else $error("Millisecond ticks too close");
  // R12 R13 compressor fields follow register
  a_comp_fields: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    ##1 comp_ctrl == {$past(comp_reg[6]), $past(comp_reg[4:0])})
    else $error("Compressor settings stale");
  // Level interrupt tracks unmasked status
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(irq_stat_reg & irq_mask_reg) |=> irq)
    else $error("Interrupt not raised");
endmodule
`default_nettype wire

/* File: dpv_consts.svh */
// Notes on behaviour
// R1 - DAC stays powered down while power bit is 0; resets to 0.
// R2 - Source field: 00 off, 01 left, 10 right, 11 average; reset left.
// R3 - Soft-step: 00 one step per sample, 01 per two samples, 10 none.
// R4 - Software never writes 11 into the soft-step field.
// R5 - Mute bit 1 silences output, 0 passes audio; resets muted.
// R6 - Gain is signed 8-bit half-dB steps, +48 down to -127; 0 is 0 dB.
// R7 - Software never writes gain 49..127 or -128.
// R8 - Enabled headset status: 00 none, 01 no mic, 11 with mic.
// R9 - Headset debounce 16 ms every 2 ms, doubling to 512 ms every 64 ms.
// R10 - Button debounce none, 8/1 ms, 16/2 ms or 32/4 ms.
// R11 - Debounce timing divides down the 1 MHz reference clock.
// R12 - Compressor threshold -3 dB down to -24 dB in 3 dB steps; reset -12.
// R13 - Compressor hysteresis 0..3 dB by code; reset 3 dB.
// R14 - Software writes zeros or reset values into reserved fields.
// R15 - Soft-stepping moves applied gain 0.5 dB per step toward target.
`ifndef DPV_CONSTS_SVH
`define DPV_CONSTS_SVH
// Register indices; byte address is four times the index
`define DPV_IDX_SETUP    10'h03F
`define DPV_IDX_MUTE     10'h040
`define DPV_IDX_GAIN     10'h041
`define DPV_IDX_RSVD66   10'h042
`define DPV_IDX_HEADSET  10'h043
`define DPV_IDX_COMP     10'h044
`define DPV_IDX_IRQ_STAT 10'h050
`define DPV_IDX_IRQ_MASK 10'h051
// Reset values
`define DPV_RST_SETUP    8'h14
`define DPV_RST_MUTE     8'h0C
`define DPV_RST_GAIN     8'h00
`define DPV_RST_RSVD66   8'h00
`define DPV_RST_HEADSET  8'h00
`define DPV_RST_COMP     8'h0F
// Field positions
`define DPV_BIT_POWER    7
`define DPV_BIT_MUTE     3
`define DPV_BIT_HS_EN    7
`define DPV_BIT_COMP_EN  6
// Timing: reference is 1 MHz, one ms is this many reference periods
`define DPV_REF_HZ       1000000
`define DPV_MS_PER_S     1000
`define DPV_REF_PER_MS   (`DPV_REF_HZ / `DPV_MS_PER_S)
`define DPV_DEB_SAMPLES  8
// Bus answers
`define DPV_RESP_OKAY    2'h0
`define DPV_RESP_SLVERR  2'h2
`endif

/* File: dpv_pkg.sv */
`default_nettype none
package dpv_pkg;
  // Pair of incoming samples
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dpv_stereo_s;
  // Compressor settings passed on to the gain stage
  typedef struct packed {
    logic       enable;
    logic [2:0] threshold;
    logic [1:0] hysteresis;
  } dpv_comp_s;
  typedef enum logic [1:0] {
    DPV_STEP_EVERY,
    DPV_STEP_HALF,
    DPV_STEP_NONE,
    DPV_STEP_RSVD
  } dpv_step_e;
  typedef enum logic [1:0] {
    DPV_SRC_OFF,
    DPV_SRC_LEFT,
    DPV_SRC_RIGHT,
    DPV_SRC_AVG
  } dpv_src_e;
endpackage
`default_nettype wire

/* File: dpv_dac_path_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpv_consts.svh"
module dpv_dac_path_test
  import dpv_pkg::*;
;
  localparam int CYC_LIMIT = 60000;
  localparam logic [11:0] A_SETUP = {`DPV_IDX_SETUP, 2'b00};
  localparam logic [11:0] A_MUTE  = {`DPV_IDX_MUTE, 2'b00};
  localparam logic [11:0] A_GAIN  = {`DPV_IDX_GAIN, 2'b00};
  localparam logic [11:0] A_RSVD  = {`DPV_IDX_RSVD66, 2'b00};
  localparam logic [11:0] A_HS    = {`DPV_IDX_HEADSET, 2'b00};
  localparam logic [11:0] A_COMP  = {`DPV_IDX_COMP, 2'b00};
  localparam logic [11:0] A_STAT  = {`DPV_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK  = {`DPV_IDX_IRQ_MASK, 2'b00};

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [1:0]  resp;
  } dpv_row_s;

  logic        aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  dpv_stereo_s audio_in;
  logic        sample_valid, ref_clk_1mhz, ref_run;
  logic        hs_present_pin, hs_mic_pin, hs_button_pin;
  logic [15:0] dac_sample;
  logic        dac_sample_valid, dac_power_on, irq;
  logic [7:0]  dac_applied_gain, rd;
  dpv_comp_s   comp_ctrl;
  logic [1:0]  rsp;
  int          n_mismatch, total_checks, cyc, wait_cyc;

`define CHK(name, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", name, exp, got); end end

  // Ordinary register traffic: write, then expected read-back and answer
  // only legal codes written
  dpv_row_s rows [8] = '{
    '{A_SETUP, 8'h96, 8'h96, `DPV_RESP_OKAY},
    '{A_MUTE,  8'h04, 8'h04, `DPV_RESP_OKAY},
    '{A_GAIN,  8'h30, 8'h30, `DPV_RESP_OKAY},
    '{A_RSVD,  8'h00, 8'h00, `DPV_RESP_OKAY},
    '{A_HS,    8'h15, 8'h15, `DPV_RESP_OKAY},
    '{A_COMP,  8'h41, 8'h41, `DPV_RESP_OKAY},
    '{A_MASK,  8'h03, 8'h03, `DPV_RESP_OKAY},
    '{12'h200, 8'h55, 8'h00, `DPV_RESP_SLVERR}
  };
  logic [11:0] rst_addr [6] = '{A_SETUP, A_MUTE, A_GAIN, A_RSVD, A_HS, A_COMP};
  logic [7:0]  rst_val  [6] = '{`DPV_RST_SETUP, `DPV_RST_MUTE, `DPV_RST_GAIN,
                                `DPV_RST_RSVD66, `DPV_RST_HEADSET, `DPV_RST_COMP};
  // Source codes off, left, right, average of 8000 and C000
  logic [15:0] src_exp  [4] = '{16'h0000, 16'h8000, 16'hC000, 16'hA000};

  dpv_dac_path i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .audio_in(audio_in),
    .sample_valid(sample_valid), .ref_clk_1mhz(ref_clk_1mhz),
    .hs_present_pin(hs_present_pin), .hs_mic_pin(hs_mic_pin),
    .hs_button_pin(hs_button_pin), .dac_sample(dac_sample),
    .dac_sample_valid(dac_sample_valid), .dac_power_on(dac_power_on),
    .dac_applied_gain(dac_applied_gain), .comp_ctrl(comp_ctrl), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a fast reference so debounce fits in the run
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  // Reference toggles every cycle: one ms is 2000 clock cycles here
  always @(posedge aclk) begin
    if (ref_run) begin
      ref_clk_1mhz <= ~ref_clk_1mhz;
    end
  end

  // Cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == CYC_LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Offers address and data together, releases each once taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [7:0] d,
                        output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    `CHK("rdata_upper", 24'h000000, s_axi_rdata[31:8])
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask

  // One sample period; outputs are sampled the cycle after the pulse
  task automatic play(input logic [15:0] l, input logic [15:0] r);
    audio_in     <= '{left: l, right: r};
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    // Answers always accepted at once, so the ready lines never toggle
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {sample_valid, ref_run} = '0;
    {hs_present_pin, hs_mic_pin, hs_button_pin, ref_clk_1mhz} = '0;
    s_axi_wstrb = 4'hF;
    audio_in = '0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Table of register writes and read-backs, unmapped place last
    foreach (rows[i]) begin
      axi_wr(rows[i].addr, rows[i].wd, rsp);
      `CHK("bresp", rows[i].resp, rsp)
      axi_rd(rows[i].addr, rd, rsp);
      `CHK("rresp", rows[i].resp, rsp)
      `CHK("rdata", rows[i].rd, rd)
    end
    `CHK("power", 1'b1, dac_power_on)
    `CHK("comp", 6'h21, comp_ctrl)
    `CHK("gain_now", 8'h30, dac_applied_gain)
    for (int s = 0; s < 4; s++) begin
      axi_wr(A_SETUP, 8'h86 | 8'(s << 4), rsp);
      play(16'h8000, 16'hC000);
      `CHK("valid", 1'b1, dac_sample_valid)
      `CHK("sample", src_exp[s], dac_sample)
    end
    axi_wr(A_MUTE, 8'h0C, rsp);
    play(16'h1234, 16'h0000);
    `CHK("muted", 16'h0000, dac_sample)
    axi_wr(A_MUTE, 8'h04, rsp);
    axi_wr(A_SETUP, 8'h14, rsp);
    play(16'h1234, 16'h0000);
    `CHK("off_valid", 1'b0, dac_sample_valid)
    `CHK("off_power", 1'b0, dac_power_on)
    // one step per sample up to the target, from 45 set unstepped
    axi_wr(A_SETUP, 8'h96, rsp);
    axi_wr(A_GAIN, 8'h2D, rsp);
    axi_wr(A_SETUP, 8'h94, rsp);
    axi_wr(A_GAIN, 8'h30, rsp);
    for (int k = 1; k <= 4; k++) begin
      play(16'h0001, 16'h0000);
      `CHK("step1", 8'(k < 4 ? 45 + k : 48), dac_applied_gain)
    end
    // one step per two samples, downward
    axi_wr(A_SETUP, 8'h95, rsp);
    axi_wr(A_GAIN, 8'h2E, rsp);
    for (int k = 1; k <= 6; k++) begin
      play(16'h0001, 16'h0000);
      if (k % 2 == 0) begin
        `CHK("step2", 8'(k < 4 ? 47 : 46), dac_applied_gain)
      end
    end
    // lowest legal gain applied at once without stepping
    axi_wr(A_SETUP, 8'h96, rsp);
    axi_wr(A_GAIN, 8'h81, rsp);
    repeat (2) @(posedge aclk);
    `CHK("gain_min", 8'h81, dac_applied_gain)
    // headset with mic, 16 ms debounce on the 2 ms sample tick
    axi_wr(A_MASK, 8'h01, rsp);
    axi_wr(A_HS, 8'h80, rsp);
    hs_present_pin <= 1'b1;
    hs_mic_pin     <= 1'b1;
    ref_run        <= 1'b1;
    wait_cyc = 0;
    do begin
      @(posedge aclk);
      wait_cyc++;
    end while (!irq);
    `CHK("deb_early", 1'b1, wait_cyc >= 31900)
    `CHK("deb_late", 1'b1, wait_cyc <= 36200)
    axi_rd(A_HS, rd, rsp);
    `CHK("hs_status", 8'hE0, rd)
    axi_rd(A_STAT, rd, rsp);
    `CHK("irq_stat", 8'h01, rd)
    axi_wr(A_STAT, 8'h01, rsp);
    repeat (2) @(posedge aclk);
    `CHK("irq_clr", 1'b0, irq)
    // undebounced press, masked until the mask opens
    hs_button_pin <= 1'b1;
    rd = 8'h00;
    for (int k = 0; k < 20 && rd != 8'h02; k++) begin
      axi_rd(A_STAT, rd, rsp);
    end
    `CHK("btn_stat", 8'h02, rd)
    `CHK("irq_mask", 1'b0, irq)
    axi_wr(A_MASK, 8'h03, rsp);
    repeat (2) @(posedge aclk);
    `CHK("irq_open", 1'b1, irq)
    axi_wr(A_STAT, 8'h02, rsp);
    repeat (2) @(posedge aclk);
    `CHK("irq_clr2", 1'b0, irq)
    // Second reset in mid-run restores documented values
    {hs_present_pin, hs_mic_pin, hs_button_pin, ref_run} <= 4'h0;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_addr[i]) begin
      axi_rd(rst_addr[i], rd, rsp);
      `CHK("reset_val", rst_val[i], rd)
    end
    `CHK("rst_power", 1'b0, dac_power_on)
    `CHK("rst_comp", 6'h0F, comp_ctrl)
    `CHK("rst_irq", 1'b0, irq)
    end_sim();
  end
`undef CHK
endmodule
`default_nettype wire
